// ===== hdl/srd_defs.svh
// constants of the serial memory read path
// assumes inclusion by bare name from package and design file
// Notes on behaviour
// (RULE1) read starts like write, read bit one
// (RULE2) pointer holds last address plus one
// (RULE3) ack read control byte, send byte
// (RULE4) nack then stop ends transmission
// (RULE5) master loads address with write command
// (RULE6) repeated start abandons write, keeps address
// (RULE7) resent read control acked, loaded byte sent
// (RULE8) after random read pointer is next
// (RULE9) master ack requests next sequential byte
// (RULE10) master ends sequence with nack, stop
// (RULE11) pointer increments after each byte
// (RULE12) pointer wraps from top to zero
// (RULE13) control byte: type, selects, direction bit
// (RULE14) address high byte first, top bit ignored
// (RULE15) no ack while programming cycle runs
// (RULE16) release data line after master nack
// (RULE17) start or stop mid-byte aborts, pointer kept
`ifndef SRD_DEFS_SVH
`define SRD_DEFS_SVH
`define SRD_ADDR_W 15
`define SRD_DATA_W 8
`define SRD_FIFO_DEPTH 4
`define SRD_ACK_SLOT 4'h8
`define SRD_RW_POS 0
`define SRD_CS_MSB 3
`define SRD_CS_LSB 1
`define SRD_TYPE_MSB 7
`define SRD_TYPE_LSB 4
`define SRD_ADDR_RST 15'h0000
`define SRD_IDLE_BYTE 8'hFF
`endif

// ===== hdl/srd_pkg.sv
// types of the serial memory read path
// assumes the constants header sits beside it
`include "srd_defs.svh"
package srd_pkg;
  typedef logic [`SRD_ADDR_W-1:0] srd_addr_t;
  typedef logic [`SRD_DATA_W-1:0] srd_byte_t;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_CTRL = 6'h02,
    ST_ADRH = 6'h04,
    ST_ADRL = 6'h08,
    ST_WAIT = 6'h10,
    ST_TX = 6'h20
  } srd_state_t;
endpackage

// ===== hdl/srd_read_path.sv
// read side of a two-wire serial memory target with prefetch fifo
// assumes open-drain wire resolved outside, array answers next cycle
`timescale 1ns/1ps
`include "srd_defs.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module srd_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // filling side
  input wire logic wClk,
  input wire logic resetn,
  input wire logic wValid,
  output logic wReady,
  input wire logic [WIDTH-1:0] wData,
  // draining side
  input wire logic rClk,
  output logic rValid,
  input wire logic rReady,
  output logic [WIDTH-1:0] rData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wBin, wGray, rBin, rGray;
  logic [AW:0] rGrayMeta, rGrayW, wGrayMeta, wGrayR;
  logic [AW:0] next_wBin, next_rBin;
  logic doWrite, doRead;

  // gray pointers cross, full and empty compare synced copies
  assign wReady = (wGray != {~rGrayW[AW:AW-1], rGrayW[AW-2:0]});
  assign rValid = (rGray != wGrayR);
  assign rData = mem[rBin[AW-1:0]];
  assign doWrite = wValid & wReady;
  assign doRead = rValid & rReady;
  assign next_wBin = wBin + {{AW{1'b0}}, doWrite};
  assign next_rBin = rBin + {{AW{1'b0}}, doRead};

  always_ff @(posedge wClk) begin
    if (doWrite) begin
      mem[wBin[AW-1:0]] <= wData;
    end
  end

  always_ff @(posedge wClk or negedge resetn) begin
    if (!resetn) begin
      wBin <= '0;
      wGray <= '0;
      rGrayMeta <= '0;
      rGrayW <= '0;
    end else begin
      wBin <= next_wBin;
      wGray <= next_wBin ^ (next_wBin >> 1);
      rGrayMeta <= rGray;
      rGrayW <= rGrayMeta;
    end
  end

  always_ff @(posedge rClk or negedge resetn) begin
    if (!resetn) begin
      rBin <= '0;
      rGray <= '0;
      wGrayMeta <= '0;
      wGrayR <= '0;
    end else begin
      rBin <= next_rBin;
      rGray <= next_rBin ^ (next_rBin >> 1);
      wGrayMeta <= wGray;
      wGrayR <= wGrayMeta;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
module srd_read_path #(
  // device type code, value arbitrary
  parameter logic [3:0] DEV_TYPE_CODE = 4'h5
) (
  // system
  input wire logic ref_clk,
  input wire logic resetn,
  // two-wire link
  input wire logic sclClk,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // chip select straps and write-path busy
  input wire logic chipSelectBitHigh,
  input wire logic chipSelectBitMid,
  input wire logic chipSelectBitLow,
  input wire logic programBusy,
  // array read port
  output logic memRdEn,
  output srd_pkg::srd_addr_t memRdAddr,
  input wire srd_pkg::srd_byte_t memRdData
);
  import srd_pkg::*;

  srd_state_t state, next_state;
  logic [3:0] bitCnt;
  srd_byte_t shift, txLatch, headByte;
  srd_addr_t wordAddressBits;
  logic startTog, stopTog, startAck, stopAck, startPend, stopPend;
  logic [3:0] strapMeta, strapLink;
  logic busyLink, ctrlMatch, rxState, rxAck, ackSlot;
  logic sdaLow, txReal, addrTog, linkGen;
  logic headFresh, stale, fifoPop, fifoValid, fifoReady;
  logic [8:0] fifoHead;
  logic [2:0] addrSync;
  logic loadEvt, pend, pendGen, fetchGen;

  //////////////////////////////////////////////////////////////////////////
  // start and stop detection on data-line edges while clock high
  // toggles are stable long before the next clock edge reads them
  always_ff @(negedge sdaIn or negedge resetn) begin
    if (!resetn) begin
      startTog <= 1'b0;
    end else if (sclClk) begin
      startTog <= ~startTog;
    end
  end

  always_ff @(posedge sdaIn or negedge resetn) begin
    if (!resetn) begin
      stopTog <= 1'b0;
    end else if (sclClk) begin
      stopTog <= ~stopTog;
    end
  end

  assign startPend = startTog ^ startAck;
  assign stopPend = stopTog ^ stopAck;

  always_ff @(posedge sclClk or negedge resetn) begin
    if (!resetn) begin
      startAck <= 1'b0;
      stopAck <= 1'b0;
    end else begin
      startAck <= startTog;
      stopAck <= stopTog;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // straps and busy into the link domain
  always_ff @(posedge sclClk or negedge resetn) begin
    if (!resetn) begin
      strapMeta <= 4'h0;
      strapLink <= 4'h0;
    end else begin
      strapMeta <= {programBusy, chipSelectBitHigh, chipSelectBitMid,
                    chipSelectBitLow};
      strapLink <= strapMeta;
    end
  end

  assign busyLink = strapLink[3];
  // (RULE13) type and select match
  assign ctrlMatch = (shift[`SRD_TYPE_MSB:`SRD_TYPE_LSB] == DEV_TYPE_CODE)
                     && (shift[`SRD_CS_MSB:`SRD_CS_LSB] == strapLink[2:0]);
  assign rxState = (state == ST_CTRL) || (state == ST_ADRH) ||
                   (state == ST_ADRL);
  assign ackSlot = (bitCnt == `SRD_ACK_SLOT);
  // (RULE15) silent while programming
  assign rxAck = !busyLink &&
                 ((state == ST_CTRL) ? ctrlMatch : rxState);

  //////////////////////////////////////////////////////////////////////////
  // link state machine
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE, ST_WAIT: begin
        next_state = state;
      end
      ST_CTRL: begin
        // (RULE1) direction bit picks path
        if (ackSlot) begin
          next_state = !rxAck ? ST_IDLE :
                       shift[`SRD_RW_POS] ? ST_TX : ST_ADRH;
        end
      end
      ST_ADRH: begin
        if (ackSlot) begin
          next_state = rxAck ? ST_ADRL : ST_IDLE;
        end
      end
      ST_ADRL: begin
        if (ackSlot) begin
          next_state = rxAck ? ST_WAIT : ST_IDLE;
        end
      end
      ST_TX: begin
        // (RULE9) master ack keeps sending
        // (RULE16) nack ends sending
        if (ackSlot && sdaIn) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sclClk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      bitCnt <= 4'h0;
    end else if (startPend) begin
      // (RULE17) start restarts, first bit sampled
      state <= ST_CTRL;
      bitCnt <= 4'h1;
    end else if (stopPend) begin
      state <= ST_IDLE;
      bitCnt <= 4'h0;
    end else begin
      state <= next_state;
      if (ackSlot) begin
        bitCnt <= 4'h0;
      end else if (rxState || state == ST_TX) begin
        bitCnt <= bitCnt + 4'h1;
      end
    end
  end

  always_ff @(posedge sclClk or negedge resetn) begin
    if (!resetn) begin
      shift <= 8'h00;
    end else if (startPend) begin
      shift <= {7'h00, sdaIn};
    end else if (rxState && !ackSlot) begin
      shift <= {shift[6:0], sdaIn};
    end
  end

  // (RULE5) address loaded by write command
  always_ff @(posedge sclClk or negedge resetn) begin
    if (!resetn) begin
      wordAddressBits <= `SRD_ADDR_RST;
      addrTog <= 1'b0;
      linkGen <= 1'b0;
    end else if (!startPend && !stopPend && ackSlot && rxAck) begin
      // (RULE14) high byte first, top bit dropped
      if (state == ST_ADRH) begin
        wordAddressBits[14:8] <= shift[6:0];
      end
      // (RULE6) address kept for later read
      if (state == ST_ADRL) begin
        wordAddressBits[7:0] <= shift;
        addrTog <= ~addrTog;
        linkGen <= ~linkGen;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // data line drive on falling clock
  assign stale = fifoValid && (fifoHead[8] != linkGen);
  assign headFresh = fifoValid && !stale;
  assign headByte = headFresh ? fifoHead[7:0] : `SRD_IDLE_BYTE;

  always_ff @(negedge sclClk or negedge resetn) begin
    if (!resetn) begin
      sdaLow <= 1'b0;
      txLatch <= `SRD_IDLE_BYTE;
      txReal <= 1'b0;
    end else begin
      sdaLow <= 1'b0;
      if (rxState && ackSlot && rxAck) begin
        // (RULE3) acknowledge addressed byte
        sdaLow <= 1'b1;
      end else if (state == ST_TX && !ackSlot) begin
        // (RULE7) send byte at pointer
        if (bitCnt == 4'h0) begin
          sdaLow <= ~headByte[7];
          txLatch <= {headByte[6:0], 1'b1};
          txReal <= headFresh;
        end else begin
          sdaLow <= ~txLatch[7];
          txLatch <= {txLatch[6:0], 1'b1};
        end
      end
    end
  end

  // (RULE4) stop releases the line at once
  assign sdaOe = sdaLow && !startPend && !stopPend;
  assign sdaOut = 1'b0;

  // (RULE8) pop moves pointer past byte
  // (RULE11) byte completion pops the head
  assign fifoPop = stale || (state == ST_TX && ackSlot && txReal &&
                             !startPend && !stopPend);
  assign fifoReady = fifoValid && fifoPop;

  //////////////////////////////////////////////////////////////////////////
  // prefetch engine in the system domain
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      addrSync <= 3'h0;
    end else begin
      addrSync <= {addrSync[1:0], addrTog};
    end
  end

  assign loadEvt = addrSync[1] ^ addrSync[2];
  logic fifoWReady;
  assign memRdEn = !pend && fifoWReady && !loadEvt;

  // (RULE2) fetch address runs ahead of pointer
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      memRdAddr <= `SRD_ADDR_RST;
      fetchGen <= 1'b0;
    end else if (loadEvt) begin
      memRdAddr <= wordAddressBits;
      fetchGen <= ~fetchGen;
    end else if (memRdEn) begin
      // (RULE12) natural wrap at top
      memRdAddr <= memRdAddr + 15'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pend <= 1'b0;
      pendGen <= 1'b0;
    end else begin
      pend <= memRdEn;
      pendGen <= fetchGen;
    end
  end

  srd_fifo #(.WIDTH(9), .DEPTH(`SRD_FIFO_DEPTH)) prefetchFifo (
    .wClk(ref_clk),
    .resetn(resetn),
    .wValid(pend),
    .wReady(fifoWReady),
    .wData({pendGen, memRdData}),
    .rClk(sclClk),
    .rValid(fifoValid),
    .rReady(fifoReady),
    .rData(fifoHead)
  );

  //////////////////////////////////////////////////////////////////////////
  // checks
  ctrl_ack_a: assert property ( // RULE3
    @(posedge sclClk) disable iff (!resetn)
    (state == ST_CTRL && ackSlot && ctrlMatch && !busyLink && !startPend
     && !stopPend && $stable(busyLink)) |-> sdaOe)
    else $error("matching control byte not acknowledged");

  busy_nack_a: assert property ( // RULE15
    @(posedge sclClk) disable iff (!resetn)
    (rxState && ackSlot && busyLink && $past(busyLink)) |-> !sdaOe)
    else $error("acknowledge given while busy");

  nack_stop_a: assert property ( // RULE16
    @(posedge sclClk) disable iff (!resetn)
    (state == ST_TX && ackSlot && sdaIn && !startPend && !stopPend)
    |=> (state == ST_IDLE) ##1 !sdaOe)
    else $error("line not released after nack");

  seq_next_a: assert property ( // RULE9
    @(posedge sclClk) disable iff (!resetn)
    (state == ST_TX && ackSlot && !sdaIn && !startPend && !stopPend)
    |=> (state == ST_TX && bitCnt == 4'h0))
    else $error("master ack did not continue read");

  addr_keep_a: assert property ( // RULE6
    @(posedge sclClk) disable iff (!resetn)
    (state == ST_ADRL && ackSlot && rxAck && !startPend && !stopPend)
    |=> (state == ST_WAIT && addrTog != $past(addrTog)
         && wordAddressBits[7:0] == $past(shift)))
    else $error("loaded address not kept");

  stop_free_a: assert property ( // RULE4
    @(posedge sclClk) disable iff (!resetn)
    stopPend |-> !sdaOe)
    else $error("line driven after stop");

  abort_start_a: assert property ( // RULE17
    @(posedge sclClk) disable iff (!resetn)
    startPend |=> (state == ST_CTRL && bitCnt == 4'h1
                   && $stable(wordAddressBits)))
    else $error("start did not restart control byte");

  ptr_step_a: assert property ( // RULE11
    @(posedge ref_clk) disable iff (!resetn)
    (memRdEn && !loadEvt) |=>
    (memRdAddr == $past(memRdAddr) + 15'h0001 && !memRdEn))
    else $error("fetch address did not step by one");

  ptr_load_a: assert property ( // RULE8
    @(posedge ref_clk) disable iff (!resetn)
    loadEvt |=> (memRdAddr == wordAddressBits && !pend))
    else $error("loaded address not taken");
endmodule

`default_nettype wire

// ===== bench/srd_bus_master.sv
// two-wire bus master model: link clock, start, stop, bits
// assumes the data line is resolved with a pull-up outside
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module srd_bus_master (
  // link
  output logic sclClk,
  output logic sdaLow,
  input wire logic sdaIn
);
  // clock stands high outside frames
  initial begin
    sclClk = 1'b1;
    sdaLow = 1'b0;
  end

  task automatic start();
    sdaLow = 1'b0;
    #16 sclClk = 1'b1;
    #16 sdaLow = 1'b1;
    #16 sclClk = 1'b0;
    #16;
  endtask

  task automatic stop();
    sdaLow = 1'b1;
    #16 sclClk = 1'b1;
    #16 sdaLow = 1'b0;
    #32;
  endtask

  // one bit; a released line reads back
  task automatic bitX(input logic drv, output logic seen);
    sdaLow = ~drv;
    #16 sclClk = 1'b1;
    #16 seen = sdaIn;
    #16 sclClk = 1'b0;
    #16;
  endtask

  task automatic byteX(input logic [7:0] tx, input logic last,
                       output logic [7:0] rx, output logic ackBit);
    for (int i = 7; i >= 0; i--) bitX(tx[i], rx[i]);
    bitX(last, ackBit);
  endtask
endmodule
`default_nettype wire

// ===== bench/srd_read_path_test.sv
// self-checking bench of the serial memory read path
// assumes design files and the bus master model compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin nTests++; if ((got) !== (exp)) begin \
  nErrors++; $display("MISMATCH %s expected %h seen %h", nm, exp, got); \
  end end

////////////////////////////////////////////////////////////////////////////
module srd_read_path_test;
  import srd_pkg::*;
  // device type code, value arbitrary
  localparam logic [3:0] TYPE_CODE = 4'h5;
  logic ref_clk = 1'b0;
  logic resetn;
  logic programBusy = 1'b0;
  logic [2:0] straps = 3'h5;
  srd_byte_t memRdData = 8'h00;
  wire logic sclClk;
  wire logic sdaLow;
  wire logic sdaWire;
  logic sdaOut;
  logic sdaOe;
  logic memRdEn;
  srd_addr_t memRdAddr;
  int nErrors = 0;
  int nTests = 0;
  logic [7:0] rx;
  logic ackBit;

  // open-drain line with pull-up
  assign sdaWire = ~(sdaLow | (sdaOe & ~sdaOut));

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  function automatic srd_byte_t memByte(input srd_addr_t a);
    return a[7:0] ^ {1'b0, a[14:8]};
  endfunction

  // array answers the cycle after a request
  always @(posedge ref_clk) begin
    if (memRdEn) begin
      memRdData <= memByte(memRdAddr);
    end
  end

  srd_read_path #(.DEV_TYPE_CODE(TYPE_CODE)) srd_read_path_i (
    .ref_clk(ref_clk), .resetn(resetn), .sclClk(sclClk), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .chipSelectBitHigh(straps[2]),
    .chipSelectBitMid(straps[1]), .chipSelectBitLow(straps[0]),
    .programBusy(programBusy), .memRdEn(memRdEn), .memRdAddr(memRdAddr),
    .memRdData(memRdData));

  srd_bus_master srd_bus_master_i (
    .sclClk(sclClk), .sdaLow(sdaLow), .sdaIn(sdaWire));

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic ctrl(input logic [2:0] cs, input logic rd,
                      input logic expAck);
    srd_bus_master_i.byteX({TYPE_CODE, cs, rd}, 1'b1, rx, ackBit);
    `CHK("control ack", ~expAck, ackBit)
  endtask

  task automatic readN(input srd_addr_t a, input int n);
    for (int i = 0; i < n; i++) begin
      srd_bus_master_i.byteX(8'hFF, i == n - 1, rx, ackBit);
      `CHK("read byte", memByte(a + 15'(i)), rx)
    end
    `CHK("line released", 1'b1, ackBit)
    srd_bus_master_i.stop();
  endtask

  task automatic tCurrent(input srd_addr_t a, input int n);
    srd_bus_master_i.start();
    ctrl(straps, 1'b1, 1'b1);
    readN(a, n);
  endtask

  task automatic tRandom(input srd_addr_t a, input int n);
    srd_bus_master_i.start();
    ctrl(straps, 1'b0, 1'b1);
    srd_bus_master_i.byteX({1'b1, a[14:8]}, 1'b1, rx, ackBit);
    `CHK("high address ack", 1'b0, ackBit)
    srd_bus_master_i.byteX(a[7:0], 1'b1, rx, ackBit);
    `CHK("low address ack", 1'b0, ackBit)
    srd_bus_master_i.start();
    ctrl(straps, 1'b1, 1'b1);
    readN(a, n);
  endtask

  task automatic tRefuse();
    srd_bus_master_i.start();
    ctrl(straps ^ 3'h2, 1'b1, 1'b0);
    srd_bus_master_i.stop();
    @(posedge ref_clk) programBusy <= 1'b1;
    srd_bus_master_i.start();
    ctrl(straps, 1'b1, 1'b0);
    srd_bus_master_i.stop();
    @(posedge ref_clk) programBusy <= 1'b0;
  endtask

  task automatic tAbort(input srd_addr_t a);
    srd_bus_master_i.start();
    ctrl(straps, 1'b0, 1'b1);
    for (int i = 0; i < 3; i++) srd_bus_master_i.bitX(1'b0, ackBit);
    srd_bus_master_i.start();
    ctrl(straps, 1'b1, 1'b1);
    readN(a, 1);
  endtask

  initial begin
    // real falling edge so the async resets act
    resetn <= 1'b0;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (20) @(posedge ref_clk);
    tCurrent(15'h0000, 2);
    tRandom(15'h7FFE, 3);
    tCurrent(15'h0001, 1);
    tRefuse();
    tCurrent(15'h0002, 1);
    tAbort(15'h0003);
    summarize();
  end

  // cut a hang short, far beyond the expected run
  initial begin
    #200000;
    nErrors++;
    summarize();
  end
endmodule
`default_nettype wire
